// *** src/psf_pkg.sv ***
// package: program status flags constants and carrier types
package psf_pkg;
  localparam logic [7:0] PSF_SFR_ADDR   = 8'hD0;  // status register address, all pages
  localparam logic [4:0] PSF_BIT_PREFIX = 5'h1A;  // bit addresses D0H..D7H share this prefix
  localparam logic [7:0] PSF_RESET_VAL  = 8'h00;
  localparam int         PSF_CY_BIT     = 7;
  localparam int         PSF_AC_BIT     = 6;
  localparam int         PSF_UF0_BIT    = 5;
  localparam int         PSF_BSH_BIT    = 4;
  localparam int         PSF_BSL_BIT    = 3;
  localparam int         PSF_OV_BIT     = 2;
  localparam int         PSF_UF1_BIT    = 1;
  localparam int         PSF_PAR_BIT    = 0;
  localparam int         PSF_BANK_SHIFT = 3;      // eight working registers per bank
  localparam logic [3:0] PSF_BCD_MAX    = 4'h9;
  localparam logic [8:0] PSF_DA_LOW     = 9'h006;
  localparam logic [8:0] PSF_DA_HIGH    = 9'h060;
  localparam logic [15:0] PSF_MUL_LIMIT = 16'h00FF;
  localparam logic [7:0] PSF_ZERO_BYTE  = 8'h00;

  typedef enum logic [2:0] {
    PSF_OP_NONE, PSF_OP_ADD, PSF_OP_ADDC, PSF_OP_SUBB,
    PSF_OP_MUL, PSF_OP_DIV, PSF_OP_DA, PSF_OP_CJNE
  } psf_op_kind_t;

  typedef struct packed {
    psf_op_kind_t kind;
    logic [7:0]   a;  // first operand (accumulator for DA)
    logic [7:0]   b;  // second operand / divisor
  } psf_op_t;

  typedef struct packed {
    logic updCy;
    logic updAc;
    logic updOv;
    logic cy;
    logic ac;
    logic ov;
  } psf_flags_t;
endpackage

// *** src/psf_flag_unit.sv ***
// flag results for one arithmetic, adjust or compare operation
`timescale 1ns/100ps
module psf_flag_unit import psf_pkg::*; (
  // operation
  input  wire psf_op_t    op,
  // current flags
  input  wire logic       carryIn,
  input  wire logic       nibbleCarryIn,
  // results
  output psf_flags_t      flags
);
  logic       cinAdd;
  logic [4:0] addLow;
  logic [7:0] addSeven;
  logic [8:0] addFull;
  logic [4:0] subLow;
  logic [7:0] subSeven;
  logic [8:0] subFull;
  logic [15:0] product;
  logic       lowAdjust;
  logic [8:0] daStep;
  logic       highAdjust;

  // add path: carries out of bit 3, bit 6 and bit 7
  assign cinAdd   = (op.kind == PSF_OP_ADDC) ? carryIn : 1'b0;
  assign addLow   = {1'b0, op.a[3:0]} + {1'b0, op.b[3:0]} + {4'h0, cinAdd};
  assign addSeven = {1'b0, op.a[6:0]} + {1'b0, op.b[6:0]} + {7'h00, cinAdd};
  assign addFull  = {1'b0, op.a} + {1'b0, op.b} + {8'h00, cinAdd};
  // subtract with borrow: borrows into bit 3, bit 6 and bit 7
  assign subLow   = {1'b0, op.a[3:0]} - {1'b0, op.b[3:0]} - {4'h0, carryIn};
  assign subSeven = {1'b0, op.a[6:0]} - {1'b0, op.b[6:0]} - {7'h00, carryIn};
  assign subFull  = {1'b0, op.a} - {1'b0, op.b} - {8'h00, carryIn};
  assign product  = op.a * op.b;
  // decimal adjust: low nibble step, then high nibble decides the carry
  assign lowAdjust  = nibbleCarryIn || (op.a[3:0] > PSF_BCD_MAX);
  assign daStep     = {1'b0, op.a} + (lowAdjust ? PSF_DA_LOW : 9'h000);
  assign highAdjust = carryIn || daStep[8] || (daStep[7:4] > PSF_BCD_MAX);

  // per-operation flag selection
  always_comb begin
    flags = '0;
    unique case (op.kind)
      PSF_OP_NONE: begin
        flags = '0;
      end
      PSF_OP_ADD, PSF_OP_ADDC: begin
        flags = '{updCy: 1'b1, updAc: 1'b1, updOv: 1'b1,
                  cy: addFull[8],
                  ac: addLow[4],
                  ov: addSeven[7] ^ addFull[8]};
      end
      PSF_OP_SUBB: begin
        flags = '{updCy: 1'b1, updAc: 1'b1, updOv: 1'b1,
                  cy: subFull[8],
                  ac: subLow[4],
                  ov: subSeven[7] ^ subFull[8]};
      end
      PSF_OP_MUL: begin
        flags = '{updCy: 1'b1, updAc: 1'b0, updOv: 1'b1,
                  cy: 1'b0,
                  ac: 1'b0,
                  ov: product > PSF_MUL_LIMIT};
      end
      PSF_OP_DIV: begin
        flags = '{updCy: 1'b1, updAc: 1'b0, updOv: 1'b1,
                  cy: 1'b0,
                  ac: 1'b0,
                  ov: op.b == PSF_ZERO_BYTE};
      end
      PSF_OP_DA: begin
        flags = '{updCy: 1'b1, updAc: 1'b0, updOv: 1'b0,
                  cy: highAdjust,
                  ac: 1'b0, ov: 1'b0};
      end
      PSF_OP_CJNE: begin
        flags = '{updCy: 1'b1, updAc: 1'b0, updOv: 1'b0,
                  cy: op.a < op.b,
                  ac: 1'b0, ov: 1'b0};
      end
    endcase
  end
endmodule

// *** src/psf_status_word.sv ***
// program status word register with flag update, bank select and parity
`timescale 1ns/100ps
module psf_status_word import psf_pkg::*; (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // special function register byte access
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrite,
  input  wire logic [7:0] sfrWrData,
  output logic [7:0]      sfrRdData,
  output logic            sfrHit,
  // bit access
  input  wire logic [7:0] bitAddr,
  input  wire logic       bitWrite,
  input  wire logic       bitWrData,
  output logic            bitRdData,
  // operation that updates flags
  input  wire psf_op_t    aluOp,
  input  wire logic [7:0] accValue,
  // status towards the core
  output logic [7:0]      statusWord,
  output logic            carryFlag,
  output logic [4:0]      bankBase
);
  logic [7:1] flagBits;        // stored writable bits
  logic [7:1] next_flagBits;
  logic [7:1] opBits;
  logic [7:1] bitWrBits;
  psf_flags_t opFlags;
  logic       byteHit;
  logic       bitHit;
  logic       parityBit;

  psf_flag_unit u_flag_unit (
    .op            (aluOp),
    .carryIn       (flagBits[PSF_CY_BIT]),
    .nibbleCarryIn (flagBits[PSF_AC_BIT]),
    .flags         (opFlags)
  );

  // address decode for byte and bit access, page is ignored
  assign byteHit   = sfrAddr == PSF_SFR_ADDR;
  assign bitHit    = bitAddr[7:3] == PSF_BIT_PREFIX;
  assign parityBit = ^accValue;

  // operation result merged into stored bits; user and bank bits untouched
  always_comb begin
    opBits = flagBits;
    if (opFlags.updCy) begin
      opBits[PSF_CY_BIT] = opFlags.cy;
    end
    if (opFlags.updAc) begin
      opBits[PSF_AC_BIT] = opFlags.ac;
    end
    if (opFlags.updOv) begin
      opBits[PSF_OV_BIT] = opFlags.ov;
    end
  end

  // single bit write; bit 0 write is dropped because parity is read-only
  always_comb begin
    bitWrBits = opBits;
    if (bitAddr[2:0] != 3'(PSF_PAR_BIT)) begin
      bitWrBits[bitAddr[2:0]] = bitWrData;
    end
  end

  // byte write overrides the same-cycle operation result; a bit write overrides only its own bit of it
  assign next_flagBits = (sfrWrite && byteHit) ? sfrWrData[7:1] :
                         (bitWrite && bitHit)  ? bitWrBits : opBits;

  // flag register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flagBits <= PSF_RESET_VAL[7:1];
    end else begin
      flagBits <= next_flagBits;
    end
  end

  // outputs
  assign statusWord = {flagBits, parityBit};
  assign carryFlag  = flagBits[PSF_CY_BIT];
  assign bankBase   = {flagBits[PSF_BSH_BIT:PSF_BSL_BIT], 3'b000};
  assign sfrRdData  = byteHit ? statusWord : PSF_ZERO_BYTE;
  assign sfrHit     = byteHit;
  assign bitRdData  = bitHit && statusWord[bitAddr[2:0]];

  // reference values used only by the checks below
  logic       hostWrite;
  logic       refCin;
  logic [8:0] refSum;
  logic [7:0] refSeven;
  logic [4:0] refNib;
  logic [8:0] refDiff;
  logic [7:0] refDiffSeven;
  logic       refLess;
  logic [15:0] refProd;
  assign hostWrite    = (sfrWrite && byteHit) || (bitWrite && bitHit);
  assign refCin       = (aluOp.kind == PSF_OP_ADDC) && carryFlag;
  assign refSum       = {1'b0, aluOp.a} + {1'b0, aluOp.b} + {8'h00, refCin};
  assign refSeven     = {1'b0, aluOp.a[6:0]} + {1'b0, aluOp.b[6:0]} + {7'h00, refCin};
  assign refNib       = {1'b0, aluOp.a[3:0]} + {1'b0, aluOp.b[3:0]} + {4'h0, refCin};
  assign refDiff      = {1'b0, aluOp.a} - {1'b0, aluOp.b} - {8'h00, carryFlag};
  assign refDiffSeven = {1'b0, aluOp.a[6:0]} - {1'b0, aluOp.b[6:0]} - {7'h00, carryFlag};
  assign refLess      = aluOp.a < aluOp.b;
  assign refProd      = aluOp.a * aluOp.b;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_add_carry;
    (aluOp.kind inside {PSF_OP_ADD, PSF_OP_ADDC} && !hostWrite) |=> carryFlag == $past(refSum[8]);
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

  property p_muldiv_carry;
    (aluOp.kind inside {PSF_OP_MUL, PSF_OP_DIV} && !hostWrite) |=> !carryFlag;
  endproperty
  a_muldiv_carry: assert property (p_muldiv_carry) else $error("mul/div left carry set");

  property p_da_carry;
    (aluOp.kind == PSF_OP_DA && (carryFlag || aluOp.a > {PSF_BCD_MAX, PSF_BCD_MAX}) && !hostWrite) |=> carryFlag;
  endproperty
  a_da_carry: assert property (p_da_carry) else $error("adjust lost carry");

  property p_cjne_carry;
    (aluOp.kind == PSF_OP_CJNE && !hostWrite) |=> carryFlag == $past(refLess);
  endproperty
  a_cjne_carry: assert property (p_cjne_carry) else $error("compare carry wrong");

  property p_nibble_carry;
    (aluOp.kind inside {PSF_OP_ADD, PSF_OP_ADDC} && !hostWrite) |=> statusWord[PSF_AC_BIT] == $past(refNib[4]);
  endproperty
  a_nibble_carry: assert property (p_nibble_carry) else $error("nibble carry wrong");

  property p_user_hold;
    (!hostWrite) [*2] |-> ($stable(statusWord[PSF_UF0_BIT]) && $stable(statusWord[PSF_UF1_BIT]));
  endproperty
  a_user_hold: assert property (p_user_hold) else $error("user flag changed by hardware");

  property p_bank;
    (sfrWrite && byteHit) |=> bankBase == {$past(sfrWrData[4:3]), 3'b000} ##1 ($stable(bankBase) || $past(hostWrite));
  endproperty
  a_bank: assert property (p_bank) else $error("bank base wrong");

  property p_add_ov;
    (aluOp.kind inside {PSF_OP_ADD, PSF_OP_ADDC} && !hostWrite)
      |=> statusWord[PSF_OV_BIT] == ($past(refSeven[7]) ^ $past(refSum[8]));
  endproperty
  a_add_ov: assert property (p_add_ov) else $error("add overflow wrong");

  property p_sub_ov;
    (aluOp.kind == PSF_OP_SUBB && !hostWrite)
      |=> statusWord[PSF_OV_BIT] == ($past(refDiffSeven[7]) ^ $past(refDiff[8])) && carryFlag == $past(refDiff[8]);
  endproperty
  a_sub_ov: assert property (p_sub_ov) else $error("subtract overflow wrong");

  property p_mul_ov;
    (aluOp.kind == PSF_OP_MUL && !hostWrite) |=> statusWord[PSF_OV_BIT] == ($past(refProd) > PSF_MUL_LIMIT);
  endproperty
  a_mul_ov: assert property (p_mul_ov) else $error("multiply overflow wrong");

  property p_div_ov;
    (aluOp.kind == PSF_OP_DIV && !hostWrite) |=> statusWord[PSF_OV_BIT] == ($past(aluOp.b) == PSF_ZERO_BYTE);
  endproperty
  a_div_ov: assert property (p_div_ov) else $error("divide overflow wrong");

  property p_parity_ro;
    (sfrWrite && byteHit) |=> statusWord[PSF_PAR_BIT] == ^accValue;
  endproperty
  a_parity_ro: assert property (p_parity_ro) else $error("parity took written value");

  property p_reset_zero;
    @(posedge sys_clk) disable iff (1'b0) reset |=> statusWord[7:1] == PSF_RESET_VAL[7:1];
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("status not cleared by reset");

  property p_write_wins;
    (sfrWrite && byteHit) |=> statusWord[7:1] == $past(sfrWrData[7:1]);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("direct write not taken");

  c_add_overflow: cover property (aluOp.kind == PSF_OP_ADD && !hostWrite ##1 statusWord[PSF_OV_BIT]);
  c_div_zero:     cover property (aluOp.kind == PSF_OP_DIV && aluOp.b == PSF_ZERO_BYTE);
  c_bank_three:   cover property (bankBase == 5'h18);
  c_bit_write:    cover property (bitWrite && bitHit);
endmodule

// *** test/psf_status_word_tb.sv ***
// self-checking bench for the program status word block
`timescale 1ns/100ps
module psf_status_word_tb import psf_pkg::*;;
  // design ports
  logic       sys_clk;
  logic       reset;
  logic [7:0] sfrAddr;
  logic       sfrWrite;
  logic [7:0] sfrWrData;
  logic [7:0] sfrRdData;
  logic       sfrHit;
  logic [7:0] bitAddr;
  logic       bitWrite;
  logic       bitWrData;
  logic       bitRdData;
  psf_op_t    aluOp;
  logic [7:0] accValue;
  logic [7:0] statusWord;
  logic       carryFlag;
  logic [4:0] bankBase;
  int         err_total;
  int         checks;

  psf_status_word psf_status_word_i (
    .sys_clk(sys_clk), .reset(reset), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrWrData(sfrWrData),
    .sfrRdData(sfrRdData), .sfrHit(sfrHit), .bitAddr(bitAddr), .bitWrite(bitWrite), .bitWrData(bitWrData),
    .bitRdData(bitRdData), .aluOp(aluOp), .accValue(accValue), .statusWord(statusWord),
    .carryFlag(carryFlag), .bankBase(bankBase)
  );

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // byte write, strobe low for a cycle before the next one
  task automatic wr_byte(input logic [7:0] addr, input logic [7:0] data);
    sfrAddr = addr;
    sfrWrData = data;
    sfrWrite = 1'b1;
    tick(1);
    sfrWrite = 1'b0;
    tick(1);
  endtask

  task automatic wr_bit(input logic [7:0] addr, input logic val);
    bitAddr = addr;
    bitWrData = val;
    bitWrite = 1'b1;
    tick(1);
    bitWrite = 1'b0;
    tick(1);
  endtask

  // one operation, then carry, nibble carry and overflow against expectation
  task automatic run_op(input psf_op_kind_t k, input logic [7:0] a, input logic [7:0] b, input logic [2:0] exp);
    aluOp = '{k, a, b};
    tick(1);
    aluOp.kind = PSF_OP_NONE;
    tick(1);
    check("op flags", {5'h00, statusWord[7], statusWord[6], statusWord[2]}, {5'h00, exp});
    check("user and bank bits", {4'h0, statusWord[5:3], statusWord[1]}, 8'h0F);
  endtask

  task automatic t_reset;
    sfrAddr = PSF_SFR_ADDR;
    tick(1);
    check("status after reset", statusWord, 8'h00);
    check("read after reset", sfrRdData, 8'h00);
    check("hit", {7'h00, sfrHit}, 8'h01);
    check("bank base", {3'h0, bankBase}, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_regs;
    wr_byte(8'hD0, 8'hFF);
    check("byte write", statusWord, 8'hFE);
    check("byte read", sfrRdData, 8'hFE);
    check("carry out", {7'h00, carryFlag}, 8'h01);
    wr_byte(8'hD1, 8'h00);
    check("other addr write", statusWord, 8'hFE);
    check("other addr read", sfrRdData, 8'h00);
    check("other addr hit", {7'h00, sfrHit}, 8'h00);
    for (int n = 0; n < 4; n++) begin
      wr_byte(8'hD0, 8'(n << 3));
      check("bank base", {3'h0, bankBase}, 8'(n * 8));
    end
    // back-to-back writes, the second strobe follows directly
    sfrAddr = 8'hD0;
    sfrWrData = 8'h08;
    sfrWrite = 1'b1;
    tick(1);
    sfrWrData = 8'h10;
    tick(1);
    sfrWrite = 1'b0;
    tick(1);
    check("back-to-back bank", {3'h0, bankBase}, 8'h10);
    wr_byte(8'hD0, 8'hFE);
    reset = 1'b1;
    tick(1);
    reset = 1'b0;
    check("mid-run reset", statusWord, 8'h00);
    $display("test byte access done");
  endtask

  task automatic t_bits;
    wr_bit(8'hD7, 1'b1);
    check("bit carry", {7'h00, carryFlag}, 8'h01);
    wr_bit(8'hD0, 1'b1);
    wr_bit(8'hD5, 1'b1);
    wr_bit(8'hD1, 1'b1);
    wr_bit(8'hD8, 1'b1);
    check("bit writes", statusWord, 8'hA2);
    bitAddr = 8'hD5;
    tick(1);
    check("bit read", {7'h00, bitRdData}, 8'h01);
    $display("test bit access done");
  endtask

  // flags are {carry, nibble carry, overflow}
  task automatic t_ops;
    wr_byte(8'hD0, 8'h3A);
    run_op(PSF_OP_ADD, 8'h7F, 8'h01, 3'b011);
    run_op(PSF_OP_ADD, 8'hFF, 8'h01, 3'b110);
    run_op(PSF_OP_ADDC, 8'h00, 8'h00, 3'b000);
    run_op(PSF_OP_SUBB, 8'h80, 8'h01, 3'b011);
    run_op(PSF_OP_SUBB, 8'h00, 8'h01, 3'b110);
    run_op(PSF_OP_SUBB, 8'h05, 8'h02, 3'b000);
    run_op(PSF_OP_ADD, 8'hFF, 8'h01, 3'b110);
    run_op(PSF_OP_MUL, 8'h0F, 8'h11, 3'b010);
    run_op(PSF_OP_MUL, 8'h10, 8'h10, 3'b011);
    run_op(PSF_OP_DIV, 8'h07, 8'h00, 3'b011);
    run_op(PSF_OP_ADD, 8'hFF, 8'h01, 3'b110);
    run_op(PSF_OP_DIV, 8'h07, 8'h03, 3'b010);
    run_op(PSF_OP_CJNE, 8'h01, 8'h02, 3'b110);
    run_op(PSF_OP_CJNE, 8'h05, 8'h05, 3'b010);
    run_op(PSF_OP_ADD, 8'h00, 8'h00, 3'b000);
    run_op(PSF_OP_DA, 8'h12, 8'h00, 3'b000);
    run_op(PSF_OP_DA, 8'h9A, 8'h00, 3'b100);
    run_op(PSF_OP_DA, 8'h12, 8'h00, 3'b100);
    $display("test operations done");
  endtask

  task automatic t_collide;
    sfrAddr = 8'hD0;
    sfrWrData = 8'h00;
    sfrWrite = 1'b1;
    aluOp = '{PSF_OP_ADD, 8'hFF, 8'h01};
    tick(1);
    sfrWrite = 1'b0;
    aluOp.kind = PSF_OP_NONE;
    tick(1);
    check("write beats op", statusWord, 8'h00);
    $display("test collision done");
  endtask

  task automatic t_parity;
    logic [7:0] vals [6];
    vals = '{8'h00, 8'h01, 8'h03, 8'h80, 8'hFF, 8'h7E};
    bitAddr = 8'hD0;
    foreach (vals[i]) begin
      accValue = vals[i];
      #1;
      check("parity", {7'h00, statusWord[0]}, {7'h00, ^vals[i]});
      check("parity bit read", {7'h00, bitRdData}, {7'h00, ^vals[i]});
      tick(1);
    end
    $display("test parity done");
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // cut a hang short
  initial begin
    #50000;
    err_total++;
    end_sim();
  end

  // main sequence
  initial begin
    err_total = 0;
    checks = 0;
    reset = 1'b1;
    sfrAddr = 8'h00;
    sfrWrite = 1'b0;
    sfrWrData = 8'h00;
    bitAddr = 8'h00;
    bitWrite = 1'b0;
    bitWrData = 1'b0;
    aluOp = '{PSF_OP_NONE, 8'h00, 8'h00};
    accValue = 8'h00;
    tick(20);
    reset = 1'b0;
    t_reset();
    t_regs();
    t_bits();
    t_ops();
    t_collide();
    t_parity();
    end_sim();
  end
endmodule
